/* File: shared/sfc_pkg.sv */
// Package of opcodes, field positions and timing constants for the serial flash front end
// Functional notes
// - Sample serial input on serial clock rise
// - Change serial output only on clock fall
// - Chip select low activates; high means standby
// - Write protect low enforces status write lock
// - Pause pin low freezes bit shifting
// - Bytes arrive most significant bit first
// - Output released while receiving input bytes
// - Output driven only for read returns
// - Clock level at select picks mode 0/3
// - Read 03h three address; 0Bh adds dummy
// - Erases D7h/20h, D8h with address; C7h alone
// - Program 02h, address, then page data bytes
// - Decode 06h enable, 04h disable, 05h status
// - Status write 01h plus one data byte
// - B9h sleep, 9Fh id, ABh id or wake
// - Upper six address bits are ignored
// - Non-read commands act at complete select rise
// - Read address increments and wraps at top
// - Status byte repeats bit 7 to 0
// - Status write needs enable, and protect high only while bit 7 is set
// - Busy bit zero reads one while working
package sfc_pkg;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_SSE_A = 8'hD7;
  localparam logic [7:0] OP_SSE_B = 8'h20;
  localparam logic [7:0] OP_SE = 8'hD8;
  localparam logic [7:0] OP_CE = 8'hC7;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_ID1 = 8'h9F;
  localparam logic [7:0] OP_ID2 = 8'hAB;
  localparam logic [7:0] OP_PD = 8'hB9;
  localparam int ADDR_W = 18;
  localparam logic [17:0] ADDR_TOP = 18'h3FFFF;
  localparam int ST_BUSY = 0;
  localparam int ST_WEN = 1;
  localparam int ST_BP0 = 2;
  localparam int ST_BP1 = 3;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] ST_RESET = 8'h00;
  localparam logic [7:0] ST_WR_MASK = 8'h8C;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  // Busy time of the stub write engine in nanoseconds, rounded up to clock cycles below
  localparam int BUSY_TIME_NS = 1000;
  localparam int CLK_NS = 50;
  localparam int BUSY_CYC = (BUSY_TIME_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    SFC_IDLE = 3'b000,
    SFC_OPC = 3'b001,
    SFC_ARG = 3'b010,
    SFC_DOUT = 3'b011,
    SFC_DIN = 3'b100,
    SFC_SKIP = 3'b101
  } sfc_state_e;
endpackage

/* File: hw/sfc_fifo.sv */
// Small valid/ready FIFO carrying page data bytes to the program engine
module sfc_fifo import sfc_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;
  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Storage needs no reset; only pointers and the count carry state
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

/* File: hw/sfc_front_end.sv */
// Serial flash command front end: pin sampling, opcode decode and read returns
module sfc_front_end import sfc_pkg::*; #(
  parameter logic [7:0] ID1_BYTE0 = 8'h5A, // Arbitrary identification value
  parameter logic [7:0] ID1_BYTE1 = 8'h11, // Arbitrary identification value
  parameter logic [7:0] ID2_BYTE = 8'h22 // Arbitrary identification value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic pause_n,
  output logic so_o,
  output logic so_oe,
  output logic [17:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] page_data_byte,
  output logic page_data_valid,
  input wire logic page_data_ready,
  output logic [17:0] op_addr,
  output logic erase_small,
  output logic erase_sector,
  output logic erase_chip,
  output logic program_start,
  output logic status_written,
  output logic [7:0] status_out,
  output logic powered_down,
  output logic cmd_dropped
);
  // Pins are sampled on the system clock, so the serial clock must stay well below it:
  // each half period needs at least four system cycles to survive the synchronisers.
  // Every pin pays the same two-cycle lag, so their relative order is kept intact.
  // Status bits other than busy and write enable change only through a status write;
  // the array itself, and what the protect bits guard, sit outside this block.

  // Two-stage synchronisers; stage one feeds stage two only
  logic sck_s1_r, sck_s2_r;
  logic cs_s1_r, cs_s2_r;
  logic si_s1_r, si_s2_r, wp_s1_r, wp_s2_r, ps_s1_r, ps_s2_r;
  logic sck_d_r, cs_d_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
      ps_s1_r <= 1'b1;
      ps_s2_r <= 1'b1;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_s1_r <= sck;
      sck_s2_r <= sck_s1_r;
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      si_s1_r <= si;
      si_s2_r <= si_s1_r;
      wp_s1_r <= wp_n;
      wp_s2_r <= wp_s1_r;
      ps_s1_r <= pause_n;
      ps_s2_r <= ps_s1_r;
      sck_d_r <= sck_s2_r;
      cs_d_r <= cs_s2_r;
    end
  end

  logic sck_q, cs_q, active, sck_rise, sck_fall, cs_fall, cs_rise;
  assign sck_q = sck_s2_r;
  assign cs_q = cs_s2_r;
  // Pause freezes all shifting progress; chip select high means standby
  assign active = !cs_q && ps_s2_r;
  assign sck_rise = active && sck_q && !sck_d_r;
  assign sck_fall = active && !sck_q && sck_d_r;
  assign cs_fall = !cs_q && cs_d_r;
  assign cs_rise = cs_q && !cs_d_r;

  // Clock mode latch; in mode 3 the first fall after select is not a shift edge.
  // That one skipped fall is all that tells the modes apart, so no mode bit is kept.
  logic skip_fall_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      skip_fall_r <= 1'b0;
    end else if (cs_fall) begin
      skip_fall_r <= sck_q;
    end else if (sck_rise) begin
      skip_fall_r <= 1'b0;
    end
  end

  sfc_state_e state_r;
  logic [2:0] bit_r;
  logic [2:0] cyc_r;
  logic [7:0] sh_r, opc_r, out_r;
  logic [23:0] addr_r;
  logic byte_done, done_r, out_load;
  logic [7:0] byte_in;
  logic [7:0] status_r;
  logic [1:0] id_idx_r;
  logic [BUSY_CYC:0] busy_cnt_r;
  assign byte_in = {sh_r[6:0], si_s2_r};
  assign byte_done = sck_rise && (bit_r == 3'h7);

  // Commands that return data once their header has been taken
  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_READ) || (op == OP_FAST_READ) || (op == OP_RDSR) ||
              (op == OP_ID1) || (op == OP_ID2);
  endfunction
  // Header length in bytes, opcode included
  function automatic logic [2:0] hdr_len(input logic [7:0] op);
    case (op)
      OP_READ, OP_SSE_A, OP_SSE_B, OP_SE, OP_PP, OP_ID2: hdr_len = 3'h4;
      OP_FAST_READ: hdr_len = 3'h5;
      OP_WRSR: hdr_len = 3'h2;
      default: hdr_len = 3'h1;
    endcase
  endfunction

  // Bit and byte counters, cleared by select rise so each frame starts fresh.
  // The byte count saturates at seven; no header is longer than five bytes.
  always_ff @(posedge clk) begin
    if (!rstn || cs_q) begin
      bit_r <= 3'h0;
      cyc_r <= 3'h0;
      sh_r <= 8'h00;
    end else if (sck_rise) begin
      bit_r <= bit_r + 3'h1;
      sh_r <= byte_in;
      if (bit_r == 3'h7 && cyc_r != 3'h7) begin
        cyc_r <= cyc_r + 3'h1;
      end
    end
  end

  // Frame sequencer: opcode, header bytes, then output, page data or skip.
  // Bytes past a fixed-length header void the command rather than being ignored.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= SFC_IDLE;
      opc_r <= 8'h00;
      addr_r <= 24'h0;
      done_r <= 1'b0;
    end else if (cs_q) begin
      state_r <= SFC_IDLE;
    end else if (cs_fall) begin
      state_r <= SFC_OPC;
      done_r <= 1'b0;
    end else if (byte_done) begin
      case (state_r)
        SFC_OPC: begin
          opc_r <= byte_in;
          // Power down refuses every opcode but the wake byte, so none of them completes
          done_r <= (hdr_len(byte_in) == 3'h1) && !(powered_down && byte_in != OP_ID2);
          if (powered_down && byte_in != OP_ID2) begin
            state_r <= SFC_SKIP;
          end else if (hdr_len(byte_in) != 3'h1) begin
            state_r <= SFC_ARG;
          end else begin
            state_r <= is_read(byte_in) ? SFC_DOUT : SFC_SKIP;
          end
        end
        SFC_ARG: begin
          if (cyc_r < 3'h4) begin
            addr_r <= {addr_r[15:0], byte_in};
          end
          if (opc_r == OP_WRSR) begin
            addr_r[7:0] <= byte_in;
          end
          if (cyc_r + 3'h1 == hdr_len(opc_r)) begin
            done_r <= 1'b1;
            if (is_read(opc_r)) begin
              state_r <= SFC_DOUT;
            end else if (opc_r == OP_PP) begin
              state_r <= SFC_DIN;
            end else begin
              state_r <= SFC_SKIP;
            end
          end
        end
        SFC_DIN: state_r <= SFC_DIN;
        SFC_SKIP: done_r <= 1'b0; // Extra bytes void a single-byte or fixed command
        SFC_DOUT: state_r <= SFC_DOUT;
        default: state_r <= SFC_IDLE;
      endcase
    end
  end

  // Page data bytes go through the FIFO; back-pressure is reported as a dropped command
  logic pd_valid, pd_ready;
  assign pd_valid = byte_done && state_r == SFC_DIN;
  logic fifo_valid, fifo_ready;
  logic [7:0] fifo_data;
  sfc_fifo #(.W(FIFO_W), .D(FIFO_D)) i_sfc_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(pd_valid),
    .in_ready(pd_ready),
    .in_data(byte_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // Registered output stage, so the page data ports come straight from flip-flops.
  // It adds one word of buffering behind the FIFO and still moves a word per cycle.
  assign fifo_ready = !page_data_valid || page_data_ready;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      page_data_valid <= 1'b0;
      page_data_byte <= 8'h00;
    end else if (fifo_ready) begin
      page_data_valid <= fifo_valid;
      if (fifo_valid) begin
        page_data_byte <= fifo_data;
      end
    end
  end

  // Output shifter: load on first fall of each output byte, shift on others.
  // Array bytes come from mem_rdata, which must settle within one cycle of mem_addr;
  // status and identification bytes come from local state.
  assign out_load = sck_fall && !skip_fall_r && state_r == SFC_DOUT && bit_r == 3'h0;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_r <= 8'h00;
      so_o <= 1'b0;
      so_oe <= 1'b0;
      id_idx_r <= 2'h0;
      mem_addr <= 18'h0;
      mem_rd <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      if (cs_q || state_r != SFC_DOUT) begin
        so_oe <= 1'b0;
        id_idx_r <= 2'h0;
        mem_addr <= addr_r[ADDR_W-1:0];
      end else if (out_load) begin
        so_oe <= 1'b1;
        case (opc_r)
          OP_RDSR: begin
            so_o <= status_r[7];
            out_r <= {status_r[6:0], status_r[7]};
          end
          OP_ID1: begin
            so_o <= id_idx_r[0] ? ID1_BYTE1[7] : ID1_BYTE0[7];
            out_r <= id_idx_r[0] ? {ID1_BYTE1[6:0], 1'b0} : {ID1_BYTE0[6:0], 1'b0};
            id_idx_r <= id_idx_r + 2'h1;
          end
          OP_ID2: begin
            so_o <= ID2_BYTE[7];
            out_r <= {ID2_BYTE[6:0], 1'b0};
          end
          default: begin
            so_o <= mem_rdata[7];
            out_r <= {mem_rdata[6:0], 1'b0};
            mem_addr <= (mem_addr == ADDR_TOP) ? 18'h0 : mem_addr + 18'h1;
            mem_rd <= 1'b1;
          end
        endcase
      end else if (sck_fall && !skip_fall_r) begin
        so_o <= out_r[7];
        out_r <= {out_r[6:0], 1'b0};
      end else if (!so_oe) begin
        // The last address byte lands as the frame turns to output, so reload here
        mem_addr <= addr_r[ADDR_W-1:0];
      end
    end
  end

  // Commit actions only at select rise after a complete header.
  // A refused command still loads op_addr here, unless refused as busy; the host learns of it from the status byte.
  // The lock only bites while the protect pin is low; with the pin high, enable will do.
  logic commit;
  logic wrsr_ok;
  assign commit = cs_rise && done_r && !is_read(opc_r);
  assign wrsr_ok = status_r[ST_WEN] && !(status_r[ST_LOCK] && !wp_s2_r);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_r <= ST_RESET;
      busy_cnt_r <= '0;
      erase_small <= 1'b0;
      erase_sector <= 1'b0;
      erase_chip <= 1'b0;
      program_start <= 1'b0;
      status_written <= 1'b0;
      powered_down <= 1'b0;
      cmd_dropped <= 1'b0;
      op_addr <= 18'h0;
      status_out <= ST_RESET;
    end else begin
      erase_small <= 1'b0;
      erase_sector <= 1'b0;
      erase_chip <= 1'b0;
      program_start <= 1'b0;
      status_written <= 1'b0;
      cmd_dropped <= (cs_rise && !done_r && state_r != SFC_DOUT) || (pd_valid && !pd_ready);
      status_out <= status_r;
      // Stub write engine: busy holds for a fixed time so the status poll sees it
      if (busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
      status_r[ST_BUSY] <= (busy_cnt_r > 1);
      if (commit && (status_r[ST_BUSY] == 1'b0 || opc_r == OP_WRDI)) begin
        op_addr <= addr_r[ADDR_W-1:0];
        case (opc_r)
          OP_WREN: status_r[ST_WEN] <= 1'b1;
          OP_WRDI: status_r[ST_WEN] <= 1'b0;
          OP_SSE_A, OP_SSE_B, OP_SE, OP_CE, OP_PP: begin
            if (status_r[ST_WEN]) begin
              erase_small <= (opc_r == OP_SSE_A) || (opc_r == OP_SSE_B);
              erase_sector <= (opc_r == OP_SE);
              erase_chip <= (opc_r == OP_CE);
              program_start <= (opc_r == OP_PP);
              status_r[ST_WEN] <= 1'b0;
              status_r[ST_BUSY] <= 1'b1;
              busy_cnt_r <= (BUSY_CYC + 1)'(BUSY_CYC);
            end
          end
          OP_WRSR: begin
            if (wrsr_ok) begin
              status_r <= (status_r & ~ST_WR_MASK) | (addr_r[7:0] & ST_WR_MASK);
              status_r[ST_WEN] <= 1'b0;
              status_r[ST_BUSY] <= 1'b1;
              status_written <= 1'b1;
              busy_cnt_r <= (BUSY_CYC + 1)'(BUSY_CYC);
            end
          end
          OP_PD: powered_down <= 1'b1;
          OP_ID2: powered_down <= 1'b0;
          default: status_r <= status_r;
        endcase
      end else if (cs_rise && opc_r == OP_ID2 && state_r == SFC_ARG && cyc_r == 3'h1) begin
        powered_down <= 1'b0; // Lone wake byte ends power down
      end
    end
  end
endmodule

/* File: tb/sfc_front_end_monitor.sv */
// Checker for the front end serial output and commit strobes
module sfc_front_end_monitor import sfc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic [17:0] mem_addr,
  input wire logic mem_rd,
  input wire logic erase_small,
  input wire logic erase_sector,
  input wire logic erase_chip,
  input wire logic program_start,
  input wire logic status_written,
  input wire logic [7:0] status_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] fall_cnt_r;
  logic sck_q_r;
  logic commit;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Any commit strobe starts the write engine
  assign commit = erase_small | erase_sector | erase_chip | program_start | status_written;
  // Cycles since the raw clock pin fell; the synchronisers add about three
  always_ff @(posedge clk) begin
    sck_q_r <= sck;
    if (!rstn) begin
      fall_cnt_r <= 4'hF;
    end else if (sck_q_r && !sck) begin
      fall_cnt_r <= 4'h0;
    end else if (fall_cnt_r != 4'hF) begin
      fall_cnt_r <= fall_cnt_r + 4'h1;
    end
  end
  property p_desel;
    cs_n [*8] |-> !so_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("SO driven while deselected");
  property p_so_edge;
    $changed(so_o) && so_oe && $past(so_oe) |-> fall_cnt_r <= 4'h7;
  endproperty
  a_so_edge: assert property (p_so_edge) else $error("SO moved off a clock fall");
  property p_oe_rise;
    $rose(so_oe) |-> fall_cnt_r <= 4'h7 && !cs_n;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("SO enabled off a fall");
  property p_commit_cs;
    commit |-> cs_n && $past(cs_n, 2);
  endproperty
  a_commit_cs: assert property (p_commit_cs) else $error("commit while selected");
  property p_need_wen;
    commit |-> $past(status_out[ST_WEN]) && !$past(status_out[ST_BUSY]);
  endproperty
  a_need_wen: assert property (p_need_wen) else $error("commit without enable");
  property p_lock;
    (!wp_n && status_out[ST_LOCK]) [*8] |-> !status_written;
  endproperty
  a_lock: assert property (p_lock) else $error("locked status written");
  property p_addr_step;
    mem_rd |-> (mem_addr == $past(mem_addr) + 18'h1) or
      ##1 (mem_addr == $past(mem_addr, 2) + 18'h1);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("read address not stepped");
  property p_busy_set;
    commit |-> ##[0:3] status_out[ST_BUSY];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not raised");
  c_status: cover property (status_written);
  c_read: cover property (mem_rd);
  c_chip: cover property (erase_chip);
endmodule
bind sfc_front_end sfc_front_end_monitor i_sfc_front_end_monitor (.clk, .rstn, .sck, .cs_n,
  .wp_n, .so_o, .so_oe, .mem_addr, .mem_rd, .erase_small, .erase_sector, .erase_chip,
  .program_start, .status_written, .status_out);

/* File: tb/sfc_host_model.sv */
// Serial host controller model framing commands with chip select
module sfc_host_model (
  input wire logic clk,
  input wire logic so_o,
  input wire logic so_oe,
  output logic sck,
  output logic cs_n,
  output logic si
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mode3 = 1'b0;
  logic so_q = 1'b0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // A released SO line shows the inverse of its last value, never a handy level
  always @(posedge clk) begin
    if (so_oe) so_q <= so_o;
  end
  // Eight system clocks per half period keep the pin synchronisers well ahead
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask
  // Idle clock level at select picks mode 0 or 3
  task automatic start(input logic m3);
    mode3 = m3;
    sck = m3;
    half();
    cs_n = 1'b0;
    half();
  endtask
  // One byte out, top bit first; SO read at the end of each low half
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      half();
      rx[i] = so_oe ? so_o : ~so_q;
      sck = 1'b1;
      half();
    end
  endtask
  // Lone clock pulse for partial or paused bytes
  task automatic pulse();
    sck = 1'b0;
    half();
    sck = 1'b1;
    half();
  endtask
  // Clock back to idle, then deselect; only whole commands count at this edge
  task automatic stop();
    sck = mode3;
    half();
    cs_n = 1'b1;
    si = ~si;
    repeat (2) half();
  endtask
endmodule

/* File: tb/sfc_front_end_tb.sv */
// Self-checking bench for the serial flash command front end
module sfc_front_end_tb import sfc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wp_n = 1'b1;
  logic pause_n = 1'b1;
  logic page_data_ready = 1'b0;
  logic sck, cs_n, si, so_o, so_oe, mem_rd, page_data_valid, powered_down, cmd_dropped;
  logic erase_small, erase_sector, erase_chip, program_start, status_written;
  logic [17:0] mem_addr, op_addr;
  logic [7:0] mem_rdata, page_data_byte, status_out;
  logic [5:0] seen_r = 6'h00;
  logic seen_clr = 1'b0;
  logic [7:0] rx_q [$];
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  sfc_front_end i_sfc_front_end (.clk, .rstn, .sck, .cs_n, .si, .wp_n, .pause_n, .so_o, .so_oe,
    .mem_addr, .mem_rd, .mem_rdata, .page_data_byte, .page_data_valid, .page_data_ready,
    .op_addr, .erase_small, .erase_sector, .erase_chip, .program_start, .status_written,
    .status_out, .powered_down, .cmd_dropped);
  sfc_host_model i_sfc_host_model (.clk, .so_o, .so_oe, .sck, .cs_n, .si);
  always #25 clk = ~clk;
  // Array stand-in: sum of two address slices, so a wrong high part shows too
  assign mem_rdata = mem_addr[7:0] + mem_addr[17:10];
  // Strobes last one cycle, so they are gathered here; also the hang limit
  always @(posedge clk) begin
    if (seen_clr) begin
      seen_r <= 6'h00;
    end else begin
      seen_r <= seen_r | {cmd_dropped, status_written, program_start, erase_chip, erase_sector,
        erase_small};
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_addr(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The strobe record has one owner, the gathering process; this only asks it to clear
  task automatic clr_seen();
    seen_clr = 1'b1;
    @(posedge clk);
    #1 seen_clr = 1'b0;
  endtask
  // Whole frame; answers kept per byte and strobes cleared first
  task automatic frame(input logic m3, input logic [7:0] b [$]);
    logic [7:0] r;
    rx_q = {};
    clr_seen();
    i_sfc_host_model.start(m3);
    foreach (b[i]) begin
      i_sfc_host_model.xfer(b[i], r);
      rx_q.push_back(r);
    end
    i_sfc_host_model.stop();
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 100 && status_out[ST_BUSY] !== 1'b0; i++) @(posedge clk);
    #1 cmp8(status_out & 8'h01, 8'h00);
  endtask
  task automatic t_status_basic();
    cmp8(status_out, ST_RESET);
    frame(1'b0, '{OP_WREN});
    frame(1'b0, '{OP_RDSR, 8'h00});
    cmp8(rx_q[1], 8'h02);
    frame(1'b0, '{OP_WRDI});
    cmp8(status_out, 8'h00);
  endtask
  // Refused without enable and under the pin lock; busy seen while writing
  task automatic t_status_write();
    frame(1'b0, '{OP_WRSR, 8'h8C});
    cmp8({2'b00, seen_r}, 8'h00);
    frame(1'b0, '{OP_WREN});
    frame(1'b0, '{OP_WRSR, 8'hFF});
    cmp8({2'b00, seen_r}, 8'h10);
    cmp8(status_out & 8'h01, 8'h01);
    wait_ready();
    frame(1'b0, '{OP_RDSR, 8'h00, 8'h00});
    cmp8(rx_q[1] & ST_WR_MASK, 8'h8C);
    cmp8(rx_q[2], rx_q[1]);
    wp_n = 1'b0;
    frame(1'b0, '{OP_WREN});
    frame(1'b0, '{OP_WRSR, 8'h00});
    cmp8({2'b00, seen_r}, 8'h00);
    wp_n = 1'b1;
    frame(1'b0, '{OP_WREN});
    frame(1'b0, '{OP_WRSR, 8'h00});
    wait_ready();
    cmp8(status_out & ST_WR_MASK, 8'h00);
  endtask
  // Every erase and program opcode; the top six address bits are all set
  task automatic t_erase_program();
    logic [7:0] ops [5] = '{OP_SSE_A, OP_SSE_B, OP_SE, OP_CE, OP_PP};
    logic [7:0] flag [5] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08};
    logic [7:0] b [$];
    foreach (ops[i]) begin
      b = '{ops[i]};
      if (ops[i] != OP_CE) b = {b, 8'hFC, 8'h12, 8'h34};
      for (int k = 0; k < FIFO_D && ops[i] == OP_PP; k++) b.push_back(8'(16 + k));
      frame(1'b0, '{OP_WREN});
      frame(1'b0, b);
      cmp8({2'b00, seen_r}, flag[i]);
      if (ops[i] != OP_CE) cmp_addr(op_addr, 18'h01234);
      wait_ready();
    end
    // Drain the buffer, which was left holding all eight page bytes with the consumer stalled
    for (int k = 0; k < FIFO_D; k++) begin
      cmp8({7'h00, page_data_valid}, 8'h01);
      cmp8(page_data_byte, 8'(16 + k));
      page_data_ready = 1'b1;
      @(posedge clk);
      #1 page_data_ready = 1'b0;
    end
    cmp8({7'h00, page_data_valid}, 8'h00);
  endtask
  task automatic t_read();
    frame(1'b0, '{OP_READ, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00});
    cmp8(rx_q[4], 8'hFE);
    cmp8(rx_q[5], 8'h00);
    frame(1'b1, '{OP_FAST_READ, 8'h00, 8'h00, 8'h10, 8'hAA, 8'h00, 8'h00});
    cmp8(rx_q[5], 8'h10);
    cmp8(rx_q[6], 8'h11);
  endtask
  task automatic t_power();
    frame(1'b0, '{OP_PD});
    cmp8({7'h00, powered_down}, 8'h01);
    frame(1'b0, '{OP_WREN});
    cmp8(status_out & 8'h02, 8'h00);
    frame(1'b0, '{OP_ID2});
    cmp8({7'h00, powered_down}, 8'h00);
    frame(1'b0, '{OP_ID1, 8'h00, 8'h00});
    cmp8(rx_q[1], 8'h5A);
    cmp8(rx_q[2], 8'h11);
    frame(1'b0, '{OP_ID2, 8'h00, 8'h00, 8'h00, 8'h00});
    cmp8(rx_q[4], 8'h22);
  endtask
  // Half a byte is dropped; clock pulses under pause are not counted
  task automatic t_partial_pause();
    logic [7:0] r;
    clr_seen();
    i_sfc_host_model.start(1'b0);
    repeat (4) i_sfc_host_model.pulse();
    i_sfc_host_model.stop();
    cmp8({2'b00, seen_r}, 8'h20);
    frame(1'b0, '{OP_WREN});
    cmp8(status_out & 8'h02, 8'h02);
    frame(1'b0, '{OP_WRDI});
    i_sfc_host_model.start(1'b0);
    pause_n = 1'b0;
    repeat (3) i_sfc_host_model.pulse();
    pause_n = 1'b1;
    i_sfc_host_model.xfer(OP_WREN, r);
    i_sfc_host_model.stop();
    cmp8(status_out & 8'h02, 8'h02);
    frame(1'b0, '{OP_WRDI});
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_status_basic();
    t_status_write();
    t_erase_program();
    t_read();
    t_partial_pause();
    t_power();
    end_of_test();
  end
endmodule
